//--- verilog/link_act_defines.svh
// offsets, field positions, reset values and timing figures of the activation block
`ifndef LINK_ACT_DEFINES_SVH
`define LINK_ACT_DEFINES_SVH

`define CLK_PERIOD_NS 4
`define NS_PER_MS 1000000
`define POWER_ON_DELAY_MS 1000
`define REQUEST_TIMEOUT_MS 1000
`define REPLY_TIMEOUT_MS 200

`define BAD_FRAME_LIMIT 2'h3
`define CTRL_READY_REPLY 3'h0
`define CTRL_INIT_REQUEST 3'h2
`define INIT_REQUEST_LEN 5'h04
`define READY_REPLY_LEN 5'h08
`define READY_REPLY_LAST 4'h9
`define SPEC_VERSION 8'h08
`define INACT_NEVER 16'hffff

`define OFF_CONFIG 12'h000
`define OFF_TIMING 12'h004
`define OFF_STATUS 12'h008
`define OFF_MASTER_CAP 12'h00c
`define OFF_WINDOW 12'h010

`define CFG_CLK_LSB 0
`define CFG_MAC_LSB 8
`define CFG_RESUME_LSB 16
`define CFG_SELF_RESUME_BIT 24
`define CFG_MTU_LSB 25
`define TIM_INACT_LSB 0
`define TIM_POT_LSB 16
`define WIN_SIZE_LSB 0
`define WIN_ACK_BIT 8
`define WIN_FREE_LSB 16

`define CONFIG_RST 32'h00ffff01
`define TIMING_RST 32'h00ffffff
`define WINDOW_SIZE_RST 3'h4

`endif

//--- verilog/link_act_pkg.sv
// types shared by the activation block
package link_act_pkg;

  typedef enum logic [4:0] {
    ST_POWER_ON = 5'h01,
    ST_RECEIVE = 5'h02,
    ST_REPLY = 5'h04,
    ST_ACTIVE = 5'h08,
    ST_SLEEP = 5'h10
  } link_state_t;

  typedef struct packed {
    logic [7:0] spec_ver;
    logic [7:0] caps;
    logic [7:0] max_clk_mhz;
    logic [7:0] mac_ready_time;
    logic [7:0] resume_time;
    logic [15:0] inactivity_period;
    logic [7:0] power_on_delay;
  } ready_payload_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } spi_pins_t;

endpackage

//--- verilog/sync2.sv
// two-stage synchroniser for a group of pin levels
`timescale 1ns/100ps
`default_nettype none

module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("sync2 width must be at least one");
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= INIT;
      q <= INIT;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

`default_nettype wire

//--- verilog/link_activation.sv
// serial-link activation and capability exchange, slave end, with apb registers
`timescale 1ns/100ps
`default_nettype none
`include "link_act_defines.svh"

module link_activation import link_act_pkg::*; #(
  parameter logic [31:0] POWER_ON_CYCLES =
    32'(`POWER_ON_DELAY_MS * `NS_PER_MS / `CLK_PERIOD_NS),
  parameter logic [31:0] REQUEST_CYCLES =
    32'(`REQUEST_TIMEOUT_MS * `NS_PER_MS / `CLK_PERIOD_NS),
  parameter logic [31:0] REPLY_CYCLES =
    32'(`REPLY_TIMEOUT_MS * `NS_PER_MS / `CLK_PERIOD_NS)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic power_save
);

  generate
    if (POWER_ON_CYCLES == 0 || REQUEST_CYCLES == 0 || REPLY_CYCLES == 0) begin : g_chk
      $error("timing counts must be at least one cycle");
    end
  endgenerate

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  spi_pins_t pins_raw;
  spi_pins_t pins_s;
  assign pins_raw = '{sclk: spi_sclk, cs_n: spi_cs_n, mosi: spi_mosi};

  sync2 #(.WIDTH(3), .INIT(3'h2)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(pins_raw),
    .q(pins_s)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  link_state_t state_reg, state_next;
  logic [31:0] timer_reg, timer_next;
  logic [1:0] bad_reg, bad_next;
  logic sclk_d_reg, sclk_d_next;
  logic cs_d_reg, cs_d_next;
  logic [2:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] nbytes_reg, nbytes_next;
  logic [7:0] hdr_reg, hdr_next;
  logic [7:0] chk_reg, chk_next;
  logic [7:0] pay_reg [0:3];
  logic [7:0] pay_next [0:3];
  logic [31:0] mcap_reg, mcap_next;
  ready_payload_t reply_reg, reply_next;
  logic [1:0] mtu_neg_reg, mtu_neg_next;
  logic sending_reg, sending_next;
  logic [3:0] tx_idx_reg, tx_idx_next;
  logic [7:0] tx_sh_reg, tx_sh_next;
  logic miso_reg, miso_next;
  logic oe_reg, oe_next;
  logic ps_reg, ps_next;
  logic [31:0] config_reg, config_next;
  logic [31:0] timing_reg, timing_next;
  logic [2:0] win_reg, win_next;
  logic [3:0] free_reg, free_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;

  logic sclk_rise, sclk_fall, cs_fall, cs_rise, byte_done, frame_ok, wr_en, ack;
  logic [7:0] rx_byte;
  logic [7:0] resume_rep;
  logic [1:0] mtu_own;

  assign sclk_rise = pins_s.sclk & ~sclk_d_reg;
  assign sclk_fall = ~pins_s.sclk & sclk_d_reg;
  assign cs_fall = ~pins_s.cs_n & cs_d_reg;
  assign cs_rise = pins_s.cs_n & ~cs_d_reg;
  assign byte_done = sclk_rise & ~pins_s.cs_n & (bit_reg == 3'h7);
  assign rx_byte = {shift_reg[6:0], pins_s.mosi};
  assign wr_en = psel & penable & pready_reg & pwrite;
  assign ack = wr_en & (paddr == `OFF_WINDOW) & pwdata[`WIN_ACK_BIT];
  assign mtu_own = config_reg[`CFG_MTU_LSB +: 2];

  // whole, checksummed init request with the expected length
  assign frame_ok = (hdr_reg[7:5] == `CTRL_INIT_REQUEST) &&
    (hdr_reg[4:0] == `INIT_REQUEST_LEN) && (nbytes_reg == 8'h06) &&
    (bit_reg == 3'h0) && (chk_reg == 8'h00);

  function automatic logic [7:0] reply_byte(input ready_payload_t p, input logic [3:0] idx);
    logic [63:0] flat;
    logic [7:0] hdr;
    logic [7:0] sum;
    logic [7:0] r;
    flat = p;
    hdr = {`CTRL_READY_REPLY, `READY_REPLY_LEN};
    sum = hdr;
    r = hdr;
    for (int i = 1; i <= 8; i++) begin
      sum = sum ^ flat[71-8*i -: 8];
      if (idx == 4'(i)) begin
        r = flat[71-8*i -: 8];
      end
    end
    if (idx == `READY_REPLY_LAST) begin
      r = sum;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // link and activation sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg + 32'h1;
    bad_next = bad_reg;
    sclk_d_next = pins_s.sclk;
    cs_d_next = pins_s.cs_n;
    bit_next = bit_reg;
    shift_next = shift_reg;
    nbytes_next = nbytes_reg;
    hdr_next = hdr_reg;
    chk_next = chk_reg;
    for (int i = 0; i < 4; i++) begin
      pay_next[i] = pay_reg[i];
    end
    mcap_next = mcap_reg;
    reply_next = reply_reg;
    mtu_neg_next = mtu_neg_reg;
    sending_next = sending_reg;
    tx_idx_next = tx_idx_reg;
    tx_sh_next = tx_sh_reg;
    miso_next = miso_reg;
    oe_next = ~pins_s.cs_n;
    free_next = free_reg;
    resume_rep = config_reg[`CFG_RESUME_LSB +: 8];
    if (config_reg[`CFG_SELF_RESUME_BIT] &&
        (resume_rep < config_reg[`CFG_MAC_LSB +: 8])) begin
      resume_rep = config_reg[`CFG_MAC_LSB +: 8];
    end

    if (ack && free_reg < {1'b0, win_reg}) begin
      free_next = free_reg + 4'h1;
    end

    if (cs_fall) begin
      bit_next = 3'h0;
      nbytes_next = 8'h00;
      chk_next = 8'h00;
      if (state_reg == ST_SLEEP) begin
        state_next = ST_RECEIVE;
        timer_next = 32'h0;
        bad_next = 2'h0;
      end
      if (state_reg == ST_REPLY) begin
        if (tx_idx_reg == 4'h0 && !sending_reg) begin
          // a fresh frame needs a free slot; a continued one does not
          if (free_next != 4'h0) begin
            sending_next = 1'b1;
            free_next = free_next - 4'h1;
          end
        end
        tx_sh_next = reply_byte(reply_reg, tx_idx_reg);
        miso_next = tx_sh_next[7];
      end
    end

    if (sclk_rise && !pins_s.cs_n) begin
      bit_next = bit_reg + 3'h1;
      shift_next = rx_byte;
      if (byte_done) begin
        chk_next = chk_reg ^ rx_byte;
        if (nbytes_reg != 8'hff) begin
          nbytes_next = nbytes_reg + 8'h1;
        end
        if (nbytes_reg == 8'h00) begin
          hdr_next = rx_byte;
        end else if (nbytes_reg <= 8'h04) begin
          pay_next[2'(nbytes_reg - 8'h1)] = rx_byte;
        end
        if (sending_reg && tx_idx_reg == `READY_REPLY_LAST) begin
          sending_next = 1'b0;
          tx_idx_next = 4'h0;
          state_next = ST_ACTIVE;
        end
      end
    end

    if (sclk_fall && !pins_s.cs_n && sending_reg) begin
      if (bit_reg == 3'h0) begin
        tx_idx_next = tx_idx_reg + 4'h1;
        tx_sh_next = reply_byte(reply_reg, tx_idx_next);
      end else begin
        tx_sh_next = {tx_sh_reg[6:0], 1'b0};
      end
      miso_next = tx_sh_next[7];
    end

    // accesses that carry the reply are not judged as frames, except the one that carries its last byte
    if (cs_rise && !sending_reg && nbytes_reg != 8'h00) begin
      if (state_reg == ST_RECEIVE || state_reg == ST_ACTIVE) begin
        if (frame_ok) begin
          mcap_next = {pay_reg[0], pay_reg[1], pay_reg[2], pay_reg[3]};
          mtu_neg_next = (pay_reg[1][2:1] < mtu_own) ? pay_reg[1][2:1] : mtu_own;
          reply_next.spec_ver = `SPEC_VERSION;
          reply_next.caps = {5'h00, mtu_own, 1'b0};
          reply_next.max_clk_mhz = config_reg[`CFG_CLK_LSB +: 8];
          reply_next.mac_ready_time = config_reg[`CFG_MAC_LSB +: 8];
          reply_next.resume_time = resume_rep;
          reply_next.inactivity_period = ({pay_reg[2], pay_reg[3]} == `INACT_NEVER) ?
            `INACT_NEVER : timing_reg[`TIM_INACT_LSB +: 16];
          reply_next.power_on_delay = timing_reg[`TIM_POT_LSB +: 8];
          state_next = ST_REPLY;
          tx_idx_next = 4'h0;
          timer_next = 32'h0;
          bad_next = 2'h0;
        end else if (state_reg == ST_RECEIVE) begin
          bad_next = bad_reg + 2'h1;
          if (bad_next == `BAD_FRAME_LIMIT) begin
            state_next = ST_SLEEP;
          end
        end
      end
    end

    case (state_reg)
      ST_POWER_ON: begin
        if (timer_reg >= POWER_ON_CYCLES - 32'h1) begin
          state_next = ST_RECEIVE;
          timer_next = 32'h0;
        end
      end
      ST_RECEIVE: begin
        if (state_next == ST_RECEIVE && timer_reg >= REQUEST_CYCLES - 32'h1) begin
          state_next = ST_SLEEP;
        end
      end
      ST_REPLY: begin
        if (state_next == ST_REPLY && timer_reg >= REPLY_CYCLES - 32'h1) begin
          state_next = ST_RECEIVE;
          timer_next = 32'h0;
          sending_next = 1'b0;
          tx_idx_next = 4'h0;
        end
      end
      ST_ACTIVE: begin
        timer_next = 32'h0;
      end
      ST_SLEEP: begin
        timer_next = 32'h0;
      end
      default: begin
        state_next = ST_POWER_ON;
      end
    endcase
    if (!oe_next) begin
      miso_next = 1'b0;
    end
    ps_next = (state_next == ST_SLEEP);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_POWER_ON;
      timer_reg <= 32'h0;
      bad_reg <= 2'h0;
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
      bit_reg <= 3'h0;
      shift_reg <= 8'h00;
      nbytes_reg <= 8'h00;
      hdr_reg <= 8'h00;
      chk_reg <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        pay_reg[i] <= 8'h00;
      end
      mcap_reg <= 32'h0;
      reply_reg <= '0;
      mtu_neg_reg <= 2'h0;
      sending_reg <= 1'b0;
      tx_idx_reg <= 4'h0;
      tx_sh_reg <= 8'h00;
      miso_reg <= 1'b0;
      oe_reg <= 1'b0;
      ps_reg <= 1'b0;
      free_reg <= {1'b0, `WINDOW_SIZE_RST};
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      bad_reg <= bad_next;
      sclk_d_reg <= sclk_d_next;
      cs_d_reg <= cs_d_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      nbytes_reg <= nbytes_next;
      hdr_reg <= hdr_next;
      chk_reg <= chk_next;
      for (int i = 0; i < 4; i++) begin
        pay_reg[i] <= pay_next[i];
      end
      mcap_reg <= mcap_next;
      reply_reg <= reply_next;
      mtu_neg_reg <= mtu_neg_next;
      sending_reg <= sending_next;
      tx_idx_reg <= tx_idx_next;
      tx_sh_reg <= tx_sh_next;
      miso_reg <= miso_next;
      oe_reg <= oe_next;
      ps_reg <= ps_next;
      free_reg <= free_next;
    end
  end

  // ----------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------
  always_comb begin
    config_next = config_reg;
    timing_next = timing_reg;
    win_next = win_reg;
    pready_next = psel & penable & ~pready_reg;
    prdata_next = 32'h0;
    pslverr_next = 1'b0;
    if (wr_en) begin
      case (paddr)
        `OFF_CONFIG: config_next = {5'h00, pwdata[26:0]};
        `OFF_TIMING: timing_next = {8'h00, pwdata[23:0]};
        `OFF_WINDOW: begin
          if (pwdata[`WIN_SIZE_LSB +: 3] != 3'h0) begin
            win_next = pwdata[`WIN_SIZE_LSB +: 3];
          end
        end
        default: begin
        end
      endcase
    end
    if (psel && penable && !pready_reg) begin
      case (paddr)
        `OFF_CONFIG: prdata_next = config_reg;
        `OFF_TIMING: prdata_next = timing_reg;
        `OFF_STATUS: prdata_next = {23'h0, mtu_neg_reg, bad_reg, state_reg};
        `OFF_MASTER_CAP: prdata_next = mcap_reg;
        `OFF_WINDOW: prdata_next = {12'h0, free_reg, 13'h0, win_reg};
        default: pslverr_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= `CONFIG_RST;
      timing_reg <= `TIMING_RST;
      win_reg <= `WINDOW_SIZE_RST;
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      config_reg <= config_next;
      timing_reg <= timing_next;
      win_reg <= win_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign spi_miso = miso_reg;
  assign spi_miso_oe = oe_reg;
  assign power_save = ps_reg;

endmodule

`default_nettype wire

//--- testbench/link_act_checker.sv
// port assertions of the activation block
`timescale 1ns/100ps
`default_nettype none

module link_act_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic spi_cs_n,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic power_save
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pready_wait: assert property ((psel && !penable) ##1 (psel && penable) |=> pready)
    else $error("pready not one wait state after access");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_pready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_slverr_pready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_oe_select: assert property (!spi_cs_n [*5] |-> spi_miso_oe)
    else $error("miso not driven while selected");
  a_oe_release: assert property (spi_cs_n [*5] |-> !spi_miso_oe && !spi_miso)
    else $error("miso driven while deselected");
  a_wake_sleep: assert property (
    power_save && $fell(spi_cs_n) |-> ##[1:8] !power_save)
    else $error("no wake on select");
  a_sleep_hold: assert property (spi_cs_n [*4] ##0 power_save |=> power_save)
    else $error("left power saving without select");
endmodule

`default_nettype wire

//--- testbench/spi_master_model.sv
// serial master model sending and fetching frames
`timescale 1ns/100ps
`default_nettype none

module spi_master_model (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  logic [7:0] tx [16];
  logic [7:0] rx [16];

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end

  // one select period, mode 0, msb first; clock idles low outside it
  task automatic xfer(input int s, input int n);
    cs_n = 1'b0;
    for (int i = s; i < s + n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        mosi = tx[i][b];
        #32 sclk = 1'b1;
        rx[i][b] = miso;
        #32 sclk = 1'b0;
      end
    end
    #32 cs_n = 1'b1;
    // released line shows no stale level
    mosi = ~mosi;
    #200;
  endtask
endmodule

`default_nettype wire

//--- testbench/tb_spi_link_capability_activation.sv
// self-checking bench of the activation block
`timescale 1ns/100ps
`default_nettype none
`include "link_act_defines.svh"

module tb_spi_link_capability_activation import link_act_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic sclk, cs_n, mosi, miso, oe, psave, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int err_count, compares, n;
  ready_payload_t xp;
  logic [76:0] rows [5];
  localparam logic [7:0] HQ = {`CTRL_INIT_REQUEST, `INIT_REQUEST_LEN};

  link_activation #(.POWER_ON_CYCLES(32'd1000), .REQUEST_CYCLES(32'd5000),
    .REPLY_CYCLES(32'd5000)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe(oe), .power_save(psave));
  spi_master_model spi (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      print_verdict();
    end
  endtask

  task automatic frame(input logic [7:0] h, input logic [31:0] p, input logic [7:0] x);
    spi.tx[0] = h;
    for (int i = 0; i < 4; i++) spi.tx[i+1] = p[31-8*i -: 8];
    spi.tx[5] = h ^ p[31:24] ^ p[23:16] ^ p[15:8] ^ p[7:0] ^ x;
    spi.xfer(0, 6);
  endtask

  // fetch the reply over two accesses and compare every byte
  task automatic reply(input logic [15:0] inact);
    logic [79:0] x;
    xp.inactivity_period = inact;
    x = {`CTRL_READY_REPLY, `READY_REPLY_LEN, xp, 8'h00};
    for (int i = 0; i < 9; i++) x[7:0] ^= x[79-8*i -: 8];
    for (int i = 0; i < 10; i++) spi.tx[i] = 8'h00;
    spi.xfer(0, 4);
    spi.xfer(4, 6);
    for (int i = 0; i < 10; i++) begin
      check("reply", 32'(spi.rx[i]), 32'(x[79-8*i -: 8]));
    end
    check("reply hdr", 32'(spi.rx[0]), 32'h08);
    check("reply spec", 32'(spi.rx[1]), 32'(`SPEC_VERSION));
    check("reply caps", 32'(spi.rx[2]), 32'h04);
    check("reply resume", 32'(spi.rx[5]), 32'h40);
    check("reply inact", {16'h0, spi.rx[6], spi.rx[7]}, {16'h0, inact});
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] m,
    input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(nm, rd & m, x);
  endtask

  task automatic reset_dut();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic print_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    print_verdict();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rows[0] = {1'b0, `OFF_CONFIG, 32'hffffffff, 32'h00ffff01};
    rows[1] = {1'b0, `OFF_TIMING, 32'hffffffff, 32'h00ffffff};
    rows[2] = {1'b0, `OFF_STATUS, 32'h0000007f, 32'h00000001};
    rows[3] = {1'b0, `OFF_WINDOW, 32'h000f0007, 32'h00040004};
    rows[4] = {1'b1, 12'h020, 32'h00000000, 32'h00000000};
    xp = '{`SPEC_VERSION, 8'h04, 8'h10, 8'h40, 8'h40, 16'h1234, 8'h32};
    reset_dut();
    foreach (rows[i]) begin
      apb(1'b0, rows[i][75:64], 32'h0);
      check("reg", rd & rows[i][63:32], rows[i][31:0]);
      check("slverr", 32'(e), 32'(rows[i][76]));
    end
    apb(1'b1, `OFF_CONFIG, 32'h05204010);
    apb(1'b1, `OFF_TIMING, 32'h00321234);
    frame(HQ, 32'h08020100, 8'h00);
    repeat (200) @(posedge pclk);
    rdchk("early", `OFF_STATUS, 32'h7f, 32'h02);
    frame(HQ, 32'h08020100, 8'h01);
    frame(8'h64, 32'h08020100, 8'h00);
    rdchk("bad2", `OFF_STATUS, 32'h7f, 32'h42);
    frame(8'h04, 32'h08020100, 8'h00);
    check("sleep", 32'(psave), 32'h1);
    spi.tx[0] = 8'h00;
    spi.xfer(0, 1);
    rdchk("wake", `OFF_STATUS, 32'h1f, 32'h02);
    frame(HQ, 32'h08020100, 8'h00);
    rdchk("reply", `OFF_STATUS, 32'h1f, 32'h04);
    reply(16'h1234);
    rdchk("active", `OFF_STATUS, 32'h19f, 32'h088);
    rdchk("mcap", `OFF_MASTER_CAP, 32'hffffffff, 32'h08020100);
    rdchk("win1", `OFF_WINDOW, 32'h000f0007, 32'h00030004);
    frame(HQ, 32'h0802ffff, 8'h00);
    reply(16'hffff);
    rdchk("win2", `OFF_WINDOW, 32'h000f0007, 32'h00020004);
    apb(1'b1, `OFF_WINDOW, 32'h00000104);
    apb(1'b1, `OFF_WINDOW, 32'h00000000);
    rdchk("win3", `OFF_WINDOW, 32'h000f0007, 32'h00030004);
    // reply never fetched: reply timeout returns to receive, no slot taken
    frame(HQ, 32'h08020100, 8'h00);
    repeat (5100) @(posedge pclk);
    rdchk("reply_to", `OFF_STATUS, 32'h1f, 32'h02);
    rdchk("win4", `OFF_WINDOW, 32'h000f0007, 32'h00030004);
    reset_dut();
    n = 0;
    while (psave !== 1'b1 && n < 7000) begin
      @(posedge pclk);
      n++;
    end
    check("timeout", 32'(n > 5900 && n < 6100), 32'h1);
    print_verdict();
  end
endmodule

bind link_activation link_act_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .spi_cs_n(spi_cs_n), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
  .power_save(power_save));

`default_nettype wire
